// ===== core/ubs_top.sv
// Receive polarity, wake idle, break length and receiver activity logic of a serial port, with APB registers.
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module ubs_top #(
  parameter int unsigned DIV_W = 16
) (
  input  wire logic        I_CLOCK,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [7:0]  I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  input  wire logic        I_RXD,
  output logic             O_TXD
);

  ubs_pkg::ubs_cfg_type      cfg_q;
  ubs_pkg::ubs_cfg_type      cfg_d;
  ubs_pkg::ubs_evt_type      evt;
  ubs_pkg::ubs_rx_state_type rx_st_q;
  ubs_pkg::ubs_rx_state_type rx_st_d;
  ubs_pkg::ubs_tx_state_type tx_st_q;
  ubs_pkg::ubs_tx_state_type tx_st_d;
  logic [DIV_W-1:0] baud_q;
  logic [DIV_W-1:0] baud_d;
  logic             full_q;
  logic             full_d;
  logic             fe_q;
  logic             fe_d;
  logic             idle_q;
  logic             idle_d;
  logic             brkf_q;
  logic             brkf_d;
  logic             edge_q;
  logic             edge_d;
  logic [31:0]      prdata_d;
  logic             pready_d;
  logic             pslverr_d;
  logic             wr_en;
  logic             rd_map;
  logic [5:0]       idx;
  logic             tx_start;
  logic             rx_in;
  logic             rx_prev_q;
  logic             rx_prev_d;
  logic             active_q;
  logic             active_d;
  logic             armed_q;
  logic             armed_d;
  logic [3:0]       bit_q;
  logic [3:0]       bit_d;
  logic [3:0]       low_q;
  logic [3:0]       low_d;
  logic [3:0]       idle_cnt_q;
  logic [3:0]       idle_cnt_d;
  logic [8:0]       shift_q;
  logic [8:0]       shift_d;
  logic [8:0]       rdata_q;
  logic [8:0]       rdata_d;
  logic             rx_restart;
  logic             rx_tick;
  logic [3:0]       tx_cnt_q;
  logic [3:0]       tx_cnt_d;
  logic             txd_d;
  logic             tx_tick;
  logic [3:0]       frame_bits;
  logic [3:0]       rx_thresh;
  logic [3:0]       tx_len;
  logic [3:0]       data_bits;

  // Frame lengths: plain frame, receive break threshold and sent break length.
  ubs_frame_len u_len_frame (
    .i_nine     (cfg_q.nine_bit_select),
    .i_two_stop (cfg_q.two_stop_select),
    .i_extra    (ubs_pkg::EXT_NONE),
    .o_len      (frame_bits)
  );

  ubs_frame_len u_len_rx (
    .i_nine     (cfg_q.nine_bit_select),
    .i_two_stop (cfg_q.two_stop_select),
    .i_extra    (cfg_q.break_detect_extension ? ubs_pkg::EXT_RX : ubs_pkg::EXT_NONE),
    .o_len      (rx_thresh)
  );

  ubs_frame_len u_len_tx (
    .i_nine     (cfg_q.nine_bit_select),
    .i_two_stop (cfg_q.two_stop_select),
    .i_extra    (cfg_q.long_break_select ? ubs_pkg::EXT_TX : ubs_pkg::EXT_NONE),
    .o_len      (tx_len)
  );

  // Bit-rate ticks for the receiver, resynchronised on every start edge.
  ubs_div #(.WIDTH(DIV_W)) u_div_rx (
    .i_clk     (I_CLOCK),
    .i_rst     (I_RST),
    .i_restart (rx_restart),
    .i_half    (1'b1),
    .i_divisor (baud_q),
    .o_tick    (rx_tick)
  );

  // Bit-rate ticks for the transmitter, aligned to the break request.
  ubs_div #(.WIDTH(DIV_W)) u_div_tx (
    .i_clk     (I_CLOCK),
    .i_rst     (I_RST),
    .i_restart (tx_start),
    .i_half    (1'b0),
    .i_divisor (baud_q),
    .o_tick    (tx_tick)
  );

  assign data_bits = cfg_q.nine_bit_select ? ubs_pkg::DATA_BITS9 : ubs_pkg::DATA_BITS8;
  assign rx_in     = I_RXD ^ cfg_q.rx_polarity_invert;
  assign idx       = I_PADDR[7:2];
  assign wr_en     = I_PSEL & I_PENABLE & I_PWRITE & O_PREADY;
  assign tx_start  = wr_en && idx == ubs_pkg::IDX_CTRL && I_PWDATA[ubs_pkg::CTRL_BRK] && tx_st_q == ubs_pkg::TX_IDLE;

  // APB slave and register file; every flag lets a hardware set win over a software clear.
  always_comb
  begin
    cfg_d     = cfg_q;
    baud_d    = baud_q;
    prdata_d  = O_PRDATA;
    pready_d  = I_PSEL & I_PENABLE & ~O_PREADY;
    pslverr_d = 1'b0;
    rd_map    = 1'b1;
    full_d    = full_q | evt.rx_full_set;
    fe_d      = fe_q | evt.framing_set;
    idle_d    = idle_q | evt.idle_set;
    brkf_d    = brkf_q | evt.break_set;
    edge_d    = edge_q | evt.edge_set;
    if (evt.wake)
      cfg_d.receiver_standby = 1'b0;
    if (pready_d)
    begin
      prdata_d = '0;
      case (idx)
        ubs_pkg::IDX_CTRL:
        begin
          prdata_d[ubs_pkg::CTRL_NINE] = cfg_q.nine_bit_select;
          prdata_d[ubs_pkg::CTRL_TWO]  = cfg_q.two_stop_select;
          prdata_d[ubs_pkg::CTRL_STBY] = cfg_q.receiver_standby;
          prdata_d[ubs_pkg::CTRL_BRK]  = tx_st_q == ubs_pkg::TX_BREAK;
        end
        ubs_pkg::IDX_BAUD:
          prdata_d[DIV_W-1:0] = baud_q;
        ubs_pkg::IDX_STAT:
        begin
          prdata_d[ubs_pkg::STAT_FULL] = full_q;
          prdata_d[ubs_pkg::STAT_FE]   = fe_q;
          prdata_d[ubs_pkg::STAT_IDLE] = idle_q;
        end
        ubs_pkg::IDX_DATA:
          prdata_d[8:0] = rdata_q;
        ubs_pkg::IDX_S2:
        begin
          prdata_d[ubs_pkg::S2_BRKF] = brkf_q;
          prdata_d[ubs_pkg::S2_EDGE] = edge_q;
          prdata_d[ubs_pkg::S2_INV]  = cfg_q.rx_polarity_invert;
          prdata_d[ubs_pkg::S2_WAKE] = cfg_q.wake_idle_flag_select;
          prdata_d[ubs_pkg::S2_LONG] = cfg_q.long_break_select;
          prdata_d[ubs_pkg::S2_EXT]  = cfg_q.break_detect_extension;
          prdata_d[ubs_pkg::S2_ACT]  = active_q;
        end
        default:
          rd_map = 1'b0;
      endcase
      pslverr_d = ~rd_map;
    end
    if (wr_en)
    begin
      case (idx)
        ubs_pkg::IDX_CTRL:
        begin
          cfg_d.nine_bit_select  = I_PWDATA[ubs_pkg::CTRL_NINE];
          cfg_d.two_stop_select  = I_PWDATA[ubs_pkg::CTRL_TWO];
          cfg_d.receiver_standby = I_PWDATA[ubs_pkg::CTRL_STBY];
        end
        ubs_pkg::IDX_BAUD:
          baud_d = I_PWDATA[DIV_W-1:0];
        ubs_pkg::IDX_STAT:
        begin
          full_d = evt.rx_full_set | (full_q & ~I_PWDATA[ubs_pkg::STAT_FULL]);
          fe_d   = evt.framing_set | (fe_q & ~I_PWDATA[ubs_pkg::STAT_FE]);
          idle_d = evt.idle_set | (idle_q & ~I_PWDATA[ubs_pkg::STAT_IDLE]);
        end
        ubs_pkg::IDX_S2:
        begin
          brkf_d = evt.break_set | (brkf_q & ~I_PWDATA[ubs_pkg::S2_BRKF]);
          edge_d = evt.edge_set | (edge_q & ~I_PWDATA[ubs_pkg::S2_EDGE]);
          cfg_d.rx_polarity_invert     = I_PWDATA[ubs_pkg::S2_INV];
          cfg_d.wake_idle_flag_select  = I_PWDATA[ubs_pkg::S2_WAKE];
          cfg_d.long_break_select      = I_PWDATA[ubs_pkg::S2_LONG];
          cfg_d.break_detect_extension = I_PWDATA[ubs_pkg::S2_EXT];
        end
        default:
          cfg_d = cfg_q;
      endcase
    end
  end

  // Register file flip-flops.
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      cfg_q     <= '0;
      baud_q    <= ubs_pkg::BAUD_RESET[DIV_W-1:0];
      full_q    <= 1'b0;
      fe_q      <= 1'b0;
      idle_q    <= 1'b0;
      brkf_q    <= 1'b0;
      edge_q    <= 1'b0;
      O_PRDATA  <= '0;
      O_PREADY  <= 1'b0;
      O_PSLVERR <= 1'b0;
    end
    else
    begin
      cfg_q     <= cfg_d;
      baud_q    <= baud_d;
      full_q    <= full_d;
      fe_q      <= fe_d;
      idle_q    <= idle_d;
      brkf_q    <= brkf_d;
      edge_q    <= edge_d;
      O_PRDATA  <= prdata_d;
      O_PREADY  <= pready_d;
      O_PSLVERR <= pslverr_d;
    end
  end

  // Receiver: start, data, stop, break and idle detection on the polarity-corrected line.
  // Consecutive low bit times are counted across the frame, so a break needs no separate timer.
  always_comb
  begin
    rx_st_d    = rx_st_q;
    rx_prev_d  = rx_in;
    active_d   = active_q;
    armed_d    = armed_q;
    bit_d      = bit_q;
    low_d      = low_q;
    idle_cnt_d = idle_cnt_q;
    shift_d    = shift_q;
    rdata_d    = rdata_q;
    rx_restart = 1'b0;
    evt        = '0;
    evt.edge_set = rx_prev_q & ~rx_in;
    if (rx_tick && rx_in == 1'b0 && low_q != ubs_pkg::CNT_MAX)
      low_d = low_q + 4'h1;
    else if (rx_tick)
      low_d = '0;
    case (rx_st_q)
      ubs_pkg::RX_IDLE:
      begin
        if (!rx_in)
        begin
          rx_st_d    = ubs_pkg::RX_START;
          rx_restart = 1'b1;
          active_d   = 1'b1;
          low_d      = '0;
          idle_cnt_d = '0;
        end
        else if (rx_tick && armed_q)
        begin
          idle_cnt_d = idle_cnt_q + 4'h1;
          if (idle_cnt_d == frame_bits)
          begin
            armed_d      = 1'b0;
            active_d     = 1'b0;
            evt.wake     = cfg_q.receiver_standby;
            evt.idle_set = ~cfg_q.receiver_standby | cfg_q.wake_idle_flag_select;
          end
        end
      end
      ubs_pkg::RX_START:
      begin
        if (rx_tick && rx_in)
        begin
          rx_st_d  = ubs_pkg::RX_IDLE; // Glitch, not a valid start bit.
          active_d = 1'b0;
        end
        else if (rx_tick)
        begin
          rx_st_d = ubs_pkg::RX_DATA;
          bit_d   = '0;
        end
      end
      ubs_pkg::RX_DATA:
      begin
        if (rx_tick)
        begin
          shift_d = cfg_q.nine_bit_select ? {rx_in, shift_q[8:1]} : {1'b0, rx_in, shift_q[7:1]};
          bit_d   = bit_q + 4'h1;
          if (bit_d == data_bits)
          begin
            rx_st_d = ubs_pkg::RX_STOP;
            bit_d   = '0;
          end
        end
      end
      ubs_pkg::RX_STOP:
      begin
        if (rx_tick && rx_in && cfg_q.two_stop_select && bit_q == 4'h0)
          bit_d = 4'h1;
        else if (rx_tick)
        begin
          rdata_d = shift_q;
          evt.rx_full_set = ~cfg_q.receiver_standby & ~cfg_q.break_detect_extension;
          // Framing check ignores long_break_select entirely.
          evt.framing_set = ~rx_in & ~cfg_q.break_detect_extension;
          armed_d = 1'b1;
          if (rx_in)
            rx_st_d = ubs_pkg::RX_IDLE;
          else if (low_d >= rx_thresh)
          begin
            evt.break_set = cfg_q.break_detect_extension;
            rx_st_d       = ubs_pkg::RX_WAITHI;
          end
          else if (low_d == frame_bits - {3'h0, ~bit_q[0] & cfg_q.two_stop_select})
            rx_st_d = ubs_pkg::RX_BREAK;
          else
            rx_st_d = ubs_pkg::RX_WAITHI;
        end
      end
      ubs_pkg::RX_BREAK:
      begin
        if (rx_tick && rx_in)
          rx_st_d = ubs_pkg::RX_IDLE;
        else if (rx_tick && low_d >= rx_thresh)
        begin
          evt.break_set = cfg_q.break_detect_extension;
          rx_st_d       = ubs_pkg::RX_WAITHI;
        end
      end
      ubs_pkg::RX_WAITHI:
      begin
        if (rx_in)
        begin
          rx_st_d    = ubs_pkg::RX_IDLE;
          idle_cnt_d = '0;
        end
      end
      default:
        rx_st_d = ubs_pkg::RX_IDLE;
    endcase
  end

  // Receiver flip-flops; the previous line level resets high so no edge is seen at reset.
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      rx_st_q    <= ubs_pkg::RX_IDLE;
      rx_prev_q  <= 1'b1;
      active_q   <= 1'b0;
      armed_q    <= 1'b0;
      bit_q      <= '0;
      low_q      <= '0;
      idle_cnt_q <= '0;
      shift_q    <= '0;
      rdata_q    <= '0;
    end
    else
    begin
      rx_st_q    <= rx_st_d;
      rx_prev_q  <= rx_prev_d;
      active_q   <= active_d;
      armed_q    <= armed_d;
      bit_q      <= bit_d;
      low_q      <= low_d;
      idle_cnt_q <= idle_cnt_d;
      shift_q    <= shift_d;
      rdata_q    <= rdata_d;
    end
  end

  // Break transmitter: holds the line low for the selected number of bit times.
  always_comb
  begin
    tx_st_d  = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    txd_d    = 1'b1;
    case (tx_st_q)
      ubs_pkg::TX_IDLE:
      begin
        if (tx_start)
        begin
          tx_st_d  = ubs_pkg::TX_BREAK;
          tx_cnt_d = tx_len;
          txd_d    = 1'b0;
        end
      end
      ubs_pkg::TX_BREAK:
      begin
        txd_d = 1'b0;
        if (tx_tick)
        begin
          tx_cnt_d = tx_cnt_q - 4'h1;
          if (tx_cnt_d == 4'h0)
          begin
            tx_st_d = ubs_pkg::TX_IDLE;
            txd_d   = 1'b1;
          end
        end
      end
      default:
        tx_st_d = ubs_pkg::TX_IDLE;
    endcase
  end

  // Transmitter flip-flops; the line idles high.
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      tx_st_q  <= ubs_pkg::TX_IDLE;
      tx_cnt_q <= '0;
      O_TXD    <= 1'b1;
    end
    else
    begin
      tx_st_q  <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      O_TXD    <= txd_d;
    end
  end

endmodule
`default_nettype wire

// ===== pkg/ubs_pkg.sv
// Package with register map, field positions, reset values, state types and carriers of the receive break block.
package ubs_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0]  IDX_CTRL   = 6'h00;
  localparam logic [5:0]  IDX_BAUD   = 6'h01;
  localparam logic [5:0]  IDX_STAT   = 6'h02;
  localparam logic [5:0]  IDX_DATA   = 6'h03;
  localparam logic [5:0]  IDX_S2     = 6'h05;

  // Control register fields.
  localparam int unsigned CTRL_NINE  = 0;
  localparam int unsigned CTRL_TWO   = 1;
  localparam int unsigned CTRL_STBY  = 2;
  localparam int unsigned CTRL_BRK   = 3;

  // Receive status register fields.
  localparam int unsigned STAT_FULL  = 0;
  localparam int unsigned STAT_FE    = 1;
  localparam int unsigned STAT_IDLE  = 2;

  // Fields of receive_break_status_control.
  localparam int unsigned S2_BRKF    = 7;
  localparam int unsigned S2_EDGE    = 6;
  localparam int unsigned S2_INV     = 4;
  localparam int unsigned S2_WAKE    = 3;
  localparam int unsigned S2_LONG    = 2;
  localparam int unsigned S2_EXT     = 1;
  localparam int unsigned S2_ACT     = 0;

  // Reset values and frame arithmetic.
  localparam logic [15:0] BAUD_RESET = 16'h0364;
  localparam logic [3:0]  FRAME_BASE = 4'ha;
  localparam logic [3:0]  EXT_NONE   = 4'h0;
  localparam logic [3:0]  EXT_RX     = 4'h1;
  localparam logic [3:0]  EXT_TX     = 4'h3;
  localparam logic [3:0]  DATA_BITS8 = 4'h8;
  localparam logic [3:0]  DATA_BITS9 = 4'h9;
  localparam logic [3:0]  CNT_MAX    = 4'hf;

  // Software configuration carried as one group.
  typedef struct packed {
    logic nine_bit_select;
    logic two_stop_select;
    logic receiver_standby;
    logic rx_polarity_invert;
    logic wake_idle_flag_select;
    logic long_break_select;
    logic break_detect_extension;
  } ubs_cfg_type;

  // One-cycle events from the receiver to the flag registers and the standby bit.
  typedef struct packed {
    logic rx_full_set;
    logic framing_set;
    logic break_set;
    logic idle_set;
    logic wake;
    logic edge_set;
  } ubs_evt_type;

  typedef enum logic [5:0] {
    RX_IDLE   = 6'b000001,
    RX_START  = 6'b000010,
    RX_DATA   = 6'b000100,
    RX_STOP   = 6'b001000,
    RX_BREAK  = 6'b010000,
    RX_WAITHI = 6'b100000
  } ubs_rx_state_type;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b01,
    TX_BREAK = 2'b10
  } ubs_tx_state_type;

endpackage

// ===== core/ubs_div.sv
// Bit-rate divider that emits a one-cycle tick per bit time, restartable at a chosen phase.
`timescale 1ns/100ps
`default_nettype none
module ubs_div #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst,
  input  wire logic             i_restart,
  input  wire logic             i_half,
  input  wire logic [WIDTH-1:0] i_divisor,
  output logic                  o_tick
);

  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;
  logic             tick_d;

  // A half-period start puts the first tick in the middle of a start bit.
  always_comb
  begin
    tick_d = 1'b0;
    if (i_restart)
      cnt_d = i_half ? (i_divisor >> 1) : i_divisor;
    else if (cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1})
    begin
      cnt_d  = i_divisor;
      tick_d = 1'b1;
    end
    else
      cnt_d = cnt_q - {{(WIDTH-1){1'b0}}, 1'b1};
  end

  // Tick is registered, so every sample lags its count by one cycle.
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cnt_q  <= '0;
      o_tick <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      o_tick <= tick_d;
    end
  end

endmodule
`default_nettype wire

// ===== core/ubs_frame_len.sv
// Length in bit times of a frame from character size, stop bits and an extra allowance.
`timescale 1ns/100ps
`default_nettype none
module ubs_frame_len (
  input  wire logic       i_nine,
  input  wire logic       i_two_stop,
  input  wire logic [3:0] i_extra,
  output logic      [3:0] o_len
);

  // Largest sum is fifteen, so four bits never overflow.
  assign o_len = ubs_pkg::FRAME_BASE + {3'h0, i_nine} + {3'h0, i_two_stop} + i_extra;

endmodule
`default_nettype wire

// ===== sim/ubs_properties.sv
// Checker with port-level properties of the receive break block, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module ubs_properties (
  input wire logic        I_CLOCK,
  input wire logic        I_RST,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_PWRITE,
  input wire logic [7:0]  I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic        I_RXD,
  input wire logic        O_TXD
);
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (I_RST);
  logic        wr, rd, rxi, prv, fall, brk_req, pend, last7, clr7, clean, nine, two, lng, inv, ext;
  logic [5:0]  idx;
  logic [15:0] baud;
  logic [3:0]  age, len;
  int unsigned tlo, rlo, rhi;
  // Completed transfers and the receive level as the receiver sees it.
  assign wr      = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE;
  assign rd      = I_PSEL && I_PENABLE && O_PREADY && !I_PWRITE;
  assign idx     = I_PADDR[7:2];
  assign rxi     = I_RXD ^ inv;
  assign fall    = prv && !rxi;
  assign brk_req = wr && idx == ubs_pkg::IDX_CTRL && I_PWDATA[3];
  assign len     = (lng ? 4'hd : 4'ha) + {3'h0, nine} + {3'h0, two};
  // Shadows of the settings and line history, since the design's state is hidden from here.
  always_ff @(posedge I_CLOCK)
  begin
    if (I_RST)
    begin
      {nine, two, lng, inv, ext, pend, last7, clr7, clean} <= 9'h000;
      {tlo, rlo, rhi} <= 96'h0;
      baud <= ubs_pkg::BAUD_RESET;
      age  <= 4'h0;
      prv  <= 1'b1;
    end
    else
    begin
      prv  <= rxi;
      tlo  <= O_TXD ? 0 : tlo + 1;
      rlo  <= rxi ? 0 : rlo + 1;
      rhi  <= rxi ? rhi + 1 : 0;
      age  <= fall ? 4'h0 : age + {3'h0, age != 4'hf};
      pend <= fall || (pend && !(wr && idx == ubs_pkg::IDX_S2 && I_PWDATA[6]));
      if (wr && idx == ubs_pkg::IDX_CTRL)
        {two, nine} <= I_PWDATA[1:0];
      if (wr && idx == ubs_pkg::IDX_BAUD)
        baud <= I_PWDATA[15:0];
      if (wr && idx == ubs_pkg::IDX_STAT && ext && I_PWDATA[1:0] == 2'b11)
        clean <= 1'b1;
      if (wr && idx == ubs_pkg::IDX_S2)
      begin
        {inv, lng, ext} <= {I_PWDATA[4], I_PWDATA[2:1]};
        clean <= clean && I_PWDATA[1];
        clr7  <= clr7 || I_PWDATA[7];
      end
      if (rd && idx == ubs_pkg::IDX_S2)
      begin
        last7 <= O_PRDATA[7];
        clr7  <= 1'b0;
      end
    end
  end
  // A one-cycle slack is allowed on break lengths because the bit divider restarts on request.
  a_brk_short: assert property ($rose(O_TXD) && !lng |-> tlo + 1 >= len * baud && tlo <= len * baud + 1)
    else $error("normal break length wrong");
  a_brk_long: assert property ($rose(O_TXD) && lng |-> tlo + 1 >= len * baud && tlo <= len * baud + 1)
    else $error("long break length wrong");
  a_brk_cause: assert property ($fell(O_TXD) |-> $past(brk_req))
    else $error("break started without a request");
  a_act_set: assert property (rd && idx == ubs_pkg::IDX_S2 && rlo >= 4 |-> O_PRDATA[0])
    else $error("active flag clear on a busy line");
  a_act_idle: assert property (rd && idx == ubs_pkg::IDX_S2 && rhi > 17 * baud |-> !O_PRDATA[0])
    else $error("active flag set on an idle line");
  a_edge_seen: assert property (rd && idx == ubs_pkg::IDX_S2 && pend && age >= 4'h6 |-> O_PRDATA[6])
    else $error("edge flag missing");
  a_ext_quiet: assert property (rd && idx == ubs_pkg::IDX_STAT && clean |-> O_PRDATA[1:0] == 2'b00)
    else $error("flag set while extension on");
  a_brk_sticky: assert property (rd && idx == ubs_pkg::IDX_S2 && last7 && !clr7 |-> O_PRDATA[7])
    else $error("break flag lost without a clear");
  a_rsv_zero: assert property (rd && idx == ubs_pkg::IDX_S2 |-> O_PRDATA[31:8] == 24'h0 && !O_PRDATA[5])
    else $error("reserved bits of status read nonzero");
  c_long_brk: cover property ($rose(O_TXD) && lng);
  c_brk_flag: cover property (rd && idx == ubs_pkg::IDX_S2 && O_PRDATA[7]);
  c_active: cover property (rd && idx == ubs_pkg::IDX_S2 && O_PRDATA[0]);
endmodule
bind ubs_top ubs_properties u_props (.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY),
  .O_PSLVERR(O_PSLVERR), .I_RXD(I_RXD), .O_TXD(O_TXD));
`default_nettype wire

// ===== sim/ubs_node.sv
// Behavioural remote serial node: sends frames on the receive line and times breaks on the transmit line.
`timescale 1ns/100ps
`default_nettype none
module ubs_node (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  int unsigned baud = 8;
  logic        inv = 1'b0;
  int unsigned run = 0;
  int unsigned brk_len = 0;
  // The line idles high; the bench flips inv to model an inverted link.
  initial o_rxd = 1'b1;
  // Every low stretch on the transmit line is timed so the bench can judge a break.
  always @(posedge i_clk)
  begin
    run <= i_txd ? 0 : run + 1;
    if (i_txd && run != 0)
      brk_len <= run;
  end
  // Drives the levels LSB first, one bit time each, then returns to the idle level.
  task automatic send(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      o_rxd <= bits[i] ^ inv;
      repeat (baud) @(posedge i_clk);
    end
    o_rxd <= ~inv;
  endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking bench for the receive break block: registers, sent breaks and received frames.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [7:0] ctl_a = {ubs_pkg::IDX_CTRL, 2'b00};
  localparam logic [7:0] sta_a = {ubs_pkg::IDX_STAT, 2'b00};
  localparam logic [7:0] s2_a  = {ubs_pkg::IDX_S2, 2'b00};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rdata;
  logic        pready, pslverr, txd, rerr;
  wire logic   rxd;
  int          fails = 0;
  int          checks = 0;
  logic [7:0]  ra [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h14};
  logic [31:0] rv [5] = '{32'h0, {16'h0, ubs_pkg::BAUD_RESET}, 32'h0, 32'h0, 32'h0};
  ubs_top dut (.I_CLOCK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr),
    .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RXD(rxd), .O_TXD(txd));
  ubs_node node (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));
  // Free-running 100 MHz clock.
  always #5 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_len(input int got, input int exp);
    checks++;
    if (got > exp + 1 || got + 1 < exp)
    begin
      fails++;
      $display("mismatch at %0t: length %0d expected %0d", $time, got, exp);
    end
  endtask
  // One APB transfer; the request stands until pready is seen high at a rising edge.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk({31'h0, pready}, 32'h1);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] mask);
    xfer(1'b0, a, 32'h0);
    chk(rdata & mask, exp);
  endtask
  // Reads until the given bit drops, bounded so a stuck flag cannot hang the run.
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    xfer(1'b0, a, 32'h0);
    while (rdata[b] !== 1'b0 && n < 400)
    begin
      xfer(1'b0, a, 32'h0);
      n++;
    end
    chk({31'h0, rdata[b]}, 32'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well beyond the few thousand cycles the tests need.
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_sim();
  end
  // Main sequence: reset values, breaks, frames, inversion, break detection and wake-up.
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 5; i++)
      rdc(ra[i], rv[i], 32'hffffffff);
    rdc(8'h10, 32'h0, 32'hffffffff);
    chk({31'h0, rerr}, 32'h1);
    xfer(1'b1, 8'h04, 32'h8);
    xfer(1'b1, s2_a, 32'hef);
    rdc(s2_a, 32'h0e, 32'hffffffff);
    xfer(1'b1, s2_a, 32'h0);
    for (int f = 0; f < 8; f++)
    begin
      xfer(1'b1, s2_a, {29'h0, f[2], 2'b00});
      // The break length follows the format already in force, so the format goes in first.
      xfer(1'b1, ctl_a, {30'h0, f[1], f[0]});
      xfer(1'b1, ctl_a, {28'h0, 2'b10, f[1], f[0]});
      poll(ctl_a, 3);
      repeat (2) @(posedge clk);
      chk_len(node.brk_len, ((f[2] ? 13 : 10) + f[0] + f[1]) * 8);
      rdc(s2_a, {29'h0, f[2], 2'b00}, 32'hff);
    end
    xfer(1'b1, ctl_a, 32'h0);
    fork
      node.send({7'h7f, 8'h55, 1'b0}, 10);
      begin
        repeat (36) @(posedge clk);
        rdc(s2_a, 32'h1, 32'h1);
      end
    join
    poll(s2_a, 0);
    rdc(s2_a, 32'h44, 32'hff);
    rdc(sta_a, 32'h5, 32'h7);
    rdc(8'h0c, 32'h55, 32'h1ff);
    // The polarity switch makes a short false start, which must be dropped.
    xfer(1'b1, s2_a, 32'h10);
    node.inv = 1'b1;
    node.send(16'h0, 0);
    repeat (32) @(posedge clk);
    xfer(1'b1, s2_a, 32'hd0);
    xfer(1'b1, sta_a, 32'h7);
    node.send({7'h7f, 8'ha3, 1'b0}, 10);
    poll(s2_a, 0);
    rdc(s2_a, 32'h50, 32'hff);
    rdc(sta_a, 32'h5, 32'h7);
    rdc(8'h0c, 32'ha3, 32'h1ff);
    xfer(1'b1, s2_a, 32'h0);
    node.inv = 1'b0;
    node.send(16'h0, 0);
    repeat (32) @(posedge clk);
    for (int k = 0; k < 4; k++)
    begin
      xfer(1'b1, s2_a, {29'h0, k == 1, k[1], 1'b0});
      xfer(1'b1, sta_a, 32'h7);
      node.send(16'h1 << (10 + (k == 3)), 11 + (k == 3));
      poll(s2_a, 0);
      rdc(sta_a, k[1] ? 32'h0 : 32'h3, 32'h3);
      rdc(s2_a, (k == 3) ? 32'h80 : 32'h0, 32'h80);
    end
    rdc(s2_a, 32'h80, 32'h80);
    xfer(1'b1, s2_a, 32'h82);
    rdc(s2_a, 32'h0, 32'h80);
    for (int w = 0; w < 2; w++)
    begin
      xfer(1'b1, s2_a, {28'h0, w[0], 3'h0});
      xfer(1'b1, sta_a, 32'h7);
      xfer(1'b1, ctl_a, 32'h4);
      node.send({7'h7f, 8'h3c, 1'b0}, 10);
      poll(s2_a, 0);
      rdc(sta_a, {29'h0, w[0], 2'b00}, 32'h7);
      rdc(ctl_a, 32'h0, 32'h4);
    end
    end_sim();
  end
endmodule
`default_nettype wire
